//--- hw/tpu_timer_pwm_unit.sv
module tpu_timer_pwm_unit
  import tpu_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // register port
  input  wire logic [tpu_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [tpu_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [tpu_pkg::DATA_W-1:0] regRdata,
  // pins in
  input  wire logic [tpu_pkg::TRIG_N-1:0] triggerInput,
  input  wire logic                       killInput,
  // pins out
  output logic                            pwmOutput,
  output logic                            pwmOutputInverted,
  output logic                            overflowOutput,
  output logic                            underflowOutput,
  output logic                            matchOutput,
  output logic                            sharedPinOutput,
  // interrupt
  output logic                            irq
);
  import tpu_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0]  period_reg;
  logic [CNT_W-1:0]  compare_reg;
  logic [DB_W-1:0]   deadband_reg;
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  capture_reg;
  logic [EVT_N-1:0]  status_reg;
  logic [EVT_N-1:0]  mask_reg;
  logic [EVT_N-1:0]  status_next;
  logic [EVT_N-1:0]  mask_next;

  logic [TRIG_N-1:0] trigMeta_reg;
  logic [TRIG_N-1:0] trigSync_reg;
  logic [TRIG_N-1:0] trigLast_reg;
  logic              killMeta_reg;
  logic              killSync_reg;
  logic              killLast_reg;

  logic              rawPwm_reg;
  logic              rawLast_reg;
  logic [DB_W-1:0]   dbCount_reg;

  logic wrCtrl;
  logic wrPeriod;
  logic wrCompare;
  logic wrDeadband;
  logic wrCount;
  logic wrStatus;
  logic wrMask;
  logic enable;
  logic reload;
  logic downMode;
  logic hitPeriod;
  logic hitZero;
  logic termHit;
  logic ovfEvt;
  logic undEvt;
  logic matEvt;
  logic capEvt;
  logic killEvt;
  logic dbDone;
  logic [SEL_W-1:0] capSel;
  logic [SEL_W-1:0] pinSel;
  logic [TRIG_N-1:0] trigRise;
  logic [EVT_N-1:0]  evtVec;
  logic [EVT_N-1:0]  clrVec;

  // write decode
  assign wrCtrl     = regWr && (regAddr == OFS_CTRL);
  assign wrPeriod   = regWr && (regAddr == OFS_PERIOD);
  assign wrCompare  = regWr && (regAddr == OFS_COMPARE);
  assign wrDeadband = regWr && (regAddr == OFS_DEADBAND);
  assign wrCount    = regWr && (regAddr == OFS_COUNT);
  assign wrStatus   = regWr && (regAddr == OFS_STATUS);
  assign wrMask     = regWr && (regAddr == OFS_MASK);

  assign enable   = ctrl_reg[CTRL_EN];
  assign reload   = ctrl_reg[CTRL_RELOAD];
  assign downMode = ctrl_reg[CTRL_DOWN];
  assign capSel   = ctrl_reg[CTRL_CAPSEL +: SEL_W];
  assign pinSel   = ctrl_reg[CTRL_PINSEL +: SEL_W];

  // pins are asynchronous: two flops before use
  always_ff @(posedge clk) begin
    if (srst) begin
      trigMeta_reg <= EVT_ZERO;
      trigSync_reg <= EVT_ZERO;
      trigLast_reg <= EVT_ZERO;
      killMeta_reg <= 1'b0;
      killSync_reg <= 1'b0;
      killLast_reg <= 1'b0;
    end else begin
      trigMeta_reg <= triggerInput;
      trigSync_reg <= trigMeta_reg;
      trigLast_reg <= trigSync_reg;
      killMeta_reg <= killInput;
      killSync_reg <= killMeta_reg;
      killLast_reg <= killSync_reg;
    end
  end

  assign trigRise = trigSync_reg & ~trigLast_reg;
  assign killEvt  = killSync_reg && !killLast_reg;

  // capture source: rising edge of the selected trigger pin
  always_comb begin
    capEvt = 1'b0;
    if (capSel < SEL_W'(TRIG_N)) begin
      capEvt = trigRise[capSel];
    end
  end

  // terminal conditions
  assign hitPeriod = (count_reg == period_reg);
  assign hitZero   = (count_reg == CNT_ZERO);
  assign ovfEvt    = enable && !downMode && hitPeriod;
  assign undEvt    = enable && downMode && hitZero;
  assign matEvt    = enable && (count_reg == compare_reg);
  assign termHit   = ovfEvt || undEvt;

  // control: halting mode drops the enable bit at the terminal count
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_reg <= regWdata[CTRL_W-1:0];
    end else if (termHit && !reload) begin
      ctrl_reg[CTRL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      period_reg   <= PERIOD_RST;
      compare_reg  <= CNT_ZERO;
      deadband_reg <= DB_ZERO;
      mask_reg     <= EVT_ZERO;
    end else begin
      if (wrPeriod) begin
        period_reg <= regWdata[CNT_W-1:0];
      end
      if (wrCompare) begin
        compare_reg <= regWdata[CNT_W-1:0];
      end
      if (wrDeadband) begin
        deadband_reg <= regWdata[DB_W-1:0];
      end
      if (wrMask) begin
        mask_reg <= regWdata[EVT_N-1:0];
      end
    end
  end

  // counter: software write wins over counting
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= CNT_ZERO;
    end else if (wrCount) begin
      count_reg <= regWdata[CNT_W-1:0];
    end else if (enable) begin
      if (!downMode) begin
        if (hitPeriod) begin
          count_reg <= reload ? CNT_ZERO : count_reg;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end else begin
        if (hitZero) begin
          count_reg <= reload ? period_reg : count_reg;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      capture_reg <= CNT_ZERO;
    end else if (capEvt) begin
      capture_reg <= count_reg;
    end
  end

  // sticky status; a new event wins over a same-cycle clear
  assign evtVec = {killEvt, capEvt, matEvt, undEvt, ovfEvt};
  assign clrVec = wrStatus ? regWdata[EVT_N-1:0] : EVT_ZERO;
  assign status_next = (status_reg & ~clrVec) | evtVec;
  // irq follows a mask write on the same edge, no extra cycle of lag
  assign mask_next   = wrMask ? regWdata[EVT_N-1:0] : mask_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      status_reg <= EVT_ZERO;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_next & mask_next);
    end
  end

  // pwm raw level: high while count is below compare
  always_ff @(posedge clk) begin
    if (srst) begin
      rawPwm_reg  <= 1'b0;
      rawLast_reg <= 1'b0;
    end else begin
      rawPwm_reg  <= (count_reg < compare_reg);
      rawLast_reg <= rawPwm_reg;
    end
  end

  // dead band: every raw edge restarts the gap counter
  always_ff @(posedge clk) begin
    if (srst) begin
      dbCount_reg <= DB_ZERO;
    end else if (rawPwm_reg != rawLast_reg) begin
      dbCount_reg <= DB_ZERO;
    end else if (!dbDone) begin
      dbCount_reg <= dbCount_reg + 1'b1;
    end
  end

  assign dbDone = (dbCount_reg >= deadband_reg) && (rawPwm_reg == rawLast_reg);

  // kill overrides both pwm outputs, no software needed; the level
  // only holds while the synced pin is asserted, released on the edge after it drops
  always_ff @(posedge clk) begin
    if (srst) begin
      pwmOutput         <= 1'b0;
      pwmOutputInverted <= 1'b0;
    end else if (killSync_reg) begin
      pwmOutput         <= ctrl_reg[CTRL_SAFE_T];
      pwmOutputInverted <= ctrl_reg[CTRL_SAFE_N];
    end else begin
      pwmOutput         <= rawPwm_reg && dbDone;
      pwmOutputInverted <= !rawPwm_reg && dbDone;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      overflowOutput  <= 1'b0;
      underflowOutput <= 1'b0;
      matchOutput     <= 1'b0;
    end else begin
      overflowOutput  <= ovfEvt;
      underflowOutput <= undEvt;
      matchOutput     <= matEvt;
    end
  end

  // shared pin mux, one cycle behind the dedicated pins
  always_ff @(posedge clk) begin
    if (srst) begin
      sharedPinOutput <= 1'b0;
    end else begin
      case (pinSel)
        PIN_INV:  sharedPinOutput <= pwmOutputInverted;
        PIN_OVF:  sharedPinOutput <= overflowOutput;
        PIN_UND:  sharedPinOutput <= underflowOutput;
        PIN_MAT:  sharedPinOutput <= matchOutput;
        PIN_TRUE: sharedPinOutput <= pwmOutput;
        default:  sharedPinOutput <= 1'b0;
      endcase
    end
  end

  // read port: data valid in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        OFS_CTRL:     regRdata <= DATA_W'(ctrl_reg);
        OFS_PERIOD:   regRdata <= DATA_W'(period_reg);
        OFS_COMPARE:  regRdata <= DATA_W'(compare_reg);
        OFS_DEADBAND: regRdata <= DATA_W'(deadband_reg);
        OFS_COUNT:    regRdata <= DATA_W'(count_reg);
        OFS_CAPTURE:  regRdata <= DATA_W'(capture_reg);
        OFS_STATUS:   regRdata <= DATA_W'(status_reg);
        OFS_MASK:     regRdata <= DATA_W'(mask_reg);
        default:      regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end
endmodule

//--- hw/tpu_pkg.sv
// Contract
// - one 16-bit counter with a software programmed period length
// - capture event copies the current count into the capture register
// - terminal count (period counting up, zero counting down) either halts or reloads, chosen by software
// - count compared with compare value sets the pwm duty cycle
// - true and inverted pwm outputs separated by a programmable dead band
// - kill input forces pwm outputs to a safe state without software
// - five trigger inputs and pwm outputs routed through pin multiplexing
package tpu_pkg;
  localparam int CNT_W  = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int TRIG_N = 5;
  localparam int DB_W   = 8;
  localparam int EVT_N  = 5;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COMPARE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DEADBAND = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK     = 8'h1C;

  // control fields
  localparam int CTRL_W       = 14;
  localparam int CTRL_EN      = 0;
  localparam int CTRL_RELOAD  = 1;
  localparam int CTRL_DOWN    = 2;
  localparam int CTRL_CAPSEL  = 4;
  localparam int CTRL_PINSEL  = 8;
  localparam int CTRL_SAFE_T  = 12;
  localparam int CTRL_SAFE_N  = 13;
  localparam int SEL_W        = 3;

  // status and mask bits
  localparam int EVT_OVF  = 0;
  localparam int EVT_UND  = 1;
  localparam int EVT_MAT  = 2;
  localparam int EVT_CAP  = 3;
  localparam int EVT_KILL = 4;

  // shared pin selections
  localparam logic [SEL_W-1:0] PIN_INV   = 3'h0;
  localparam logic [SEL_W-1:0] PIN_OVF   = 3'h1;
  localparam logic [SEL_W-1:0] PIN_UND   = 3'h2;
  localparam logic [SEL_W-1:0] PIN_MAT   = 3'h3;
  localparam logic [SEL_W-1:0] PIN_TRUE  = 3'h4;

  localparam logic [CTRL_W-1:0] CTRL_RST   = 14'h0002;
  localparam logic [CNT_W-1:0]  PERIOD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 16'h0000;
  localparam logic [DB_W-1:0]   DB_ZERO    = 8'h00;
  localparam logic [EVT_N-1:0]  EVT_ZERO   = 5'h00;
endpackage

//--- tb/tpu_timer_pwm_unit_monitor.sv
module tpu_timer_pwm_unit_monitor
  import tpu_pkg::*;
(
  // clock and reset
  input wire logic                       clk,
  input wire logic                       srst,
  // register port
  input wire logic [tpu_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tpu_pkg::DATA_W-1:0] regWdata,
  input wire logic                       regWr,
  input wire logic                       regRd,
  input wire logic [tpu_pkg::DATA_W-1:0] regRdata,
  // pins
  input wire logic [tpu_pkg::TRIG_N-1:0] triggerInput,
  input wire logic                       killInput,
  input wire logic                       pwmOutput,
  input wire logic                       pwmOutputInverted,
  input wire logic                       overflowOutput,
  input wire logic                       underflowOutput,
  input wire logic                       matchOutput,
  input wire logic                       sharedPinOutput,
  input wire logic                       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // kill passes two sync flops, so hold it long enough
  sequence s_killHeld;
    killInput [*5];
  endsequence
  property p_pair;
    !(pwmOutput && pwmOutputInverted);
  endproperty
  a_pair: assert property (p_pair) else $error("pwm pair overlap");
  property p_deadT;
    $rose(pwmOutput) |-> !$past(pwmOutputInverted);
  endproperty
  a_deadT: assert property (p_deadT) else $error("no gap before true");
  property p_deadN;
    $rose(pwmOutputInverted) |-> !$past(pwmOutput);
  endproperty
  a_deadN: assert property (p_deadN) else $error("no gap before inv");
  property p_kill;
    s_killHeld |-> $stable(pwmOutput) && $stable(pwmOutputInverted);
  endproperty
  a_kill: assert property (p_kill) else $error("pwm moved under kill");
  property p_evt;
    !(overflowOutput && underflowOutput);
  endproperty
  a_evt: assert property (p_evt) else $error("ovf and und together");
  property p_irqFall;
    $fell(irq) |-> $past(regWr);
  endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq fell alone");
  property p_shared;
    sharedPinOutput |-> $past(pwmOutputInverted) || $past(overflowOutput)
      || $past(underflowOutput) || $past(matchOutput) || $past(pwmOutput);
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin no source");
  property p_rdIdle;
    !$past(regRd) |-> regRdata == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
endmodule

bind tpu_timer_pwm_unit tpu_timer_pwm_unit_monitor u_mon (.*);

//--- tb/tpu_power_stage.sv
module tpu_power_stage
  import tpu_pkg::*;
(
  // bench requests
  input  wire logic                       clk,
  input  wire logic [tpu_pkg::TRIG_N-1:0] trigReq,
  input  wire logic                       killReq,
  // gate drives
  input  wire logic                       pwmOutput,
  input  wire logic                       pwmOutputInverted,
  // pins to block
  output logic      [tpu_pkg::TRIG_N-1:0] triggerInput,
  output logic                            killInput,
  output logic                            shootThrough
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    triggerInput = 5'h00;
    killInput = 1'b0;
    shootThrough = 1'b0;
  end
  always @(posedge clk) begin
    triggerInput <= trigReq;
    killInput <= killReq;
  end
  // both gates on would short the supply
  always @(posedge clk) begin
    if (pwmOutput && pwmOutputInverted) begin
      shootThrough <= 1'b1;
    end
  end
endmodule

//--- tb/tb_top.sv
module tb_top import tpu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [DATA_W-1:0] regWdata = 32'h0;
  logic [DATA_W-1:0] regRdata, rdv;
  logic              regWr = 1'b0, regRd = 1'b0, killReq = 1'b0;
  logic [TRIG_N-1:0] trigReq = 5'h00, triggerInput;
  logic              killInput, pwmOutput, pwmOutputInverted, shootThrough;
  logic              overflowOutput, underflowOutput, matchOutput;
  logic              sharedPinOutput, irq;
  int                error_cnt = 0, samples_checked = 0, n, h, l;
  always #5 clk = ~clk;
  tpu_timer_pwm_unit DUT (.*);
  tpu_power_stage u_stage (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic waitEv(input bit und, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while ((und ? underflowOutput : overflowOutput) !== 1'b1 && k < 100);
  endtask
  task automatic t_regs();
    rd(OFS_CTRL, rdv); chk(rdv, 32'h2);
    rd(OFS_PERIOD, rdv); chk(rdv, 32'hFFFF);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, rdv); chk(rdv, 32'h0);
  endtask
  task automatic t_count();
    wr(OFS_COUNT, 32'h0);
    wr(OFS_PERIOD, 32'h3);
    wr(OFS_CTRL, 32'h3);
    waitEv(0, n);
    waitEv(0, n); chk(n, 4);
    @(posedge clk);
    #1;
    chk(matchOutput, 1);
    chk(overflowOutput, 0);
    @(posedge clk);
    #1;
    chk(matchOutput, 0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL, 32'h1);
    waitEv(0, n);
    repeat (3) @(posedge clk);
    rd(OFS_CTRL, rdv); chk(rdv, 32'h0);
    rd(OFS_COUNT, rdv); chk(rdv, 32'h3);
    wr(OFS_CTRL, 32'h7);
    waitEv(1, n);
    waitEv(1, n); chk(n, 4);
    wr(OFS_MASK, 32'h2);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_STATUS, 32'h1F);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 0);
    wr(OFS_MASK, 32'h0);
  endtask
  task automatic t_pwm();
    wr(OFS_COUNT, 32'h0);
    wr(OFS_PERIOD, 32'h9);
    wr(OFS_COMPARE, 32'h4);
    wr(OFS_DEADBAND, 32'h1);
    wr(OFS_CTRL, 32'h3);
    repeat (25) @(posedge clk);
    h = 0;
    l = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      h += pwmOutput;
      l += pwmOutputInverted;
    end
    chk(h, 2);
    chk(l, 4);
  endtask
  task automatic t_cap();
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, 32'(i) << 4);
      wr(OFS_COUNT, 32'hA0 + 32'(i));
      @(posedge clk);
      trigReq <= 5'h01 << i;
      repeat (5) @(posedge clk);
      trigReq <= 5'h00;
      repeat (3) @(posedge clk);
      rd(OFS_CAPTURE, rdv); chk(rdv, 32'hA0 + 32'(i));
      chk(sharedPinOutput, 1);
      rd(OFS_STATUS, rdv); chk(rdv[EVT_CAP], 1);
      wr(OFS_STATUS, 32'h8);
    end
    wr(OFS_CAPTURE, 32'h0);
    rd(OFS_CAPTURE, rdv); chk(rdv, 32'hA4);
  endtask
  task automatic t_kill();
    wr(OFS_CTRL, 32'h3);
    repeat (12) @(posedge clk);
    killReq <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk({pwmOutput, pwmOutputInverted}, 0);
    chk(sharedPinOutput, 0);
    rd(OFS_STATUS, rdv); chk(rdv[EVT_KILL], 1);
    chk(shootThrough, 0);
    @(posedge clk);
    killReq <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(pwmOutputInverted, 1);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_count();
    t_pwm();
    t_cap();
    t_kill();
    end_of_test();
  end
  // run needs well under a thousand cycles
  initial begin
    #50000;
    error_cnt++;
    end_of_test();
  end
endmodule
